// file: shared/fscp_pkg.sv
package fscp_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int PAGE_BITS = 13;             // boot page limit width
  localparam int PAGE_WORDS = 512;           // instruction words per page
  localparam int IVT_CODE_WORDS = 256;       // protected code in first page
  localparam logic [PAGE_BITS-1:0] MIN_BOOT_PAGES = 13'h0001;
  localparam logic [PAGE_BITS-1:0] MIN_BOOT_PAGES_ALT = 13'h0002;
  localparam logic [PAGE_BITS-1:0] IVT_PAGE = 13'h0000;
  localparam logic [PAGE_BITS-1:0] PAGE_ONE = 13'h0001;

  // ----------------------------------------
  // region and requester encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    FSCP_REG_BOOT,
    FSCP_REG_GENERAL,
    FSCP_REG_CONFIG,
    FSCP_REG_NONE
  } fscp_region_t;

  typedef enum logic [1:0] {
    FSCP_OP_PROGRAM,
    FSCP_OP_PAGE_ERASE,
    FSCP_OP_READ
  } fscp_op_t;

  // per-region setting from the security config word
  typedef struct packed {
    logic enable;      // region protection configured
    logic codeProt;    // code-protect level (1 = protected)
    logic writeProt;   // write-protected
  } fscp_seg_cfg_t;

  typedef struct packed {
    fscp_seg_cfg_t boot;
    fscp_seg_cfg_t general;
    fscp_seg_cfg_t cfgRegion;  // configuration words region
  } fscp_sec_cfg_t;

  // flash access request
  typedef struct packed {
    logic valid;
    fscp_op_t op;
    logic [PAGE_BITS-1:0] page;      // target page
    fscp_region_t origin;            // region the executing code is in
  } fscp_req_t;

  // decision
  typedef struct packed {
    logic valid;
    logic grant;
    fscp_region_t region;
  } fscp_resp_t;

endpackage

// file: rtl/fscp_region_decode.sv
`timescale 1ns/10ps
module fscp_region_decode
  import fscp_pkg::*;
#(
  parameter int PW = PAGE_BITS
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // configuration
  input wire logic [PW-1:0] bootPageLimit,
  input wire logic alternateVectorTable,
  input wire logic bootEnable,
  input wire logic [PW-1:0] configPage,
  // derived boundaries
  output logic [PW-1:0] generalStart,
  output logic [PW-1:0] altPage,
  output logic bootActive
);

  logic [PW-1:0] minPages;
  logic [PW-1:0] limit;

  // clamp the boot size to its minimum, never past the config words
  assign minPages = alternateVectorTable ? PW'(MIN_BOOT_PAGES_ALT) // see RULE5
                                         : PW'(MIN_BOOT_PAGES); // see RULE4
  assign limit = (bootPageLimit < minPages) ? minPages
                 : (bootPageLimit > configPage) ? configPage // see RULE12
                 : bootPageLimit; // see RULE3

  // registered boundaries, all general until the boot setting is seen
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      generalStart <= PW'(IVT_PAGE);
      altPage <= PW'(IVT_PAGE);
      bootActive <= 1'b0;
    end
    else
    begin
      bootActive <= bootEnable;
      generalStart <= bootEnable ? limit : PW'(IVT_PAGE); // see RULE8
      altPage <= PW'(limit - PAGE_ONE); // see RULE5
    end
  end

endmodule

// file: rtl/fscp_guard.sv
`timescale 1ns/10ps
// Operation
// RULE1: flash is split into boot, general and config regions each set alone.
// RULE2: the security word gives each region a code-protect and write-protect.
// RULE3: a 13-bit boot page limit sizes the boot region in 512-word pages.
// RULE4: the smallest boot region is one page holding vectors and 256 words.
// RULE5: with the alternate table on, its last page holds only that table.
// RULE6: boot write protection never blocks writes to the alternate table.
// RULE7: boot code may always program or erase the last boot page. The code gives no exemption when the last boot page is the vector page.
// RULE8: the general region starts right after boot and runs to config.
// RULE9: the vector table takes general security only when boot is off.
// RULE10: vector table writes fail if boot or general is write-protected.
// RULE11: boot code is most privileged, general code the least.
// RULE12: the config region sits at the end and holds only config data.
// RULE13: general protection may be on without a boot region.
// RULE14: every program or erase is checked against the region bounds.
module fscp_guard
  import fscp_pkg::*;
#(
  parameter int PW = PAGE_BITS,
  parameter logic [PAGE_BITS-1:0] CONFIG_PAGE = 13'h003F
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // configuration words
  input wire fscp_sec_cfg_t securityConfigWord,
  input wire logic [PW-1:0] bootPageLimit,
  input wire logic alternateVectorTable,
  // request from cpu or flash controller
  input wire fscp_req_t req,
  // decision
  output fscp_resp_t resp_q,
  output logic blocked_q
);

  // ----------------------------------------
  // boundaries
  // ----------------------------------------
  logic [PW-1:0] generalStart;
  logic [PW-1:0] altPage;
  logic bootActive;

  // see RULE3 RULE4 RULE5
  fscp_region_decode #(.PW(PW)) u_decode (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bootPageLimit(bootPageLimit),
    .alternateVectorTable(alternateVectorTable),
    .bootEnable(securityConfigWord.boot.enable),
    .configPage(PW'(CONFIG_PAGE)),
    .generalStart(generalStart),
    .altPage(altPage),
    .bootActive(bootActive)
  );

  // ----------------------------------------
  // classification
  // ----------------------------------------
  // page class from the registered boot boundary
  function automatic fscp_region_t region_of(input logic [PW-1:0] pg,
                                             input logic [PW-1:0] gs);
    if (pg >= CONFIG_PAGE)
      region_of = FSCP_REG_CONFIG;   // see RULE12
    else if (pg < gs)
      region_of = FSCP_REG_BOOT;     // see RULE1
    else
      region_of = FSCP_REG_GENERAL;  // see RULE8
  endfunction

  // settings that belong to one region
  function automatic fscp_seg_cfg_t seg_of(input fscp_region_t rg,
                                           input fscp_sec_cfg_t cfg);
    unique case (rg)
      FSCP_REG_BOOT:
        seg_of = cfg.boot;
      FSCP_REG_GENERAL:
        seg_of = cfg.general;
      FSCP_REG_CONFIG:
        seg_of = cfg.cfgRegion;
      default:
        seg_of = '0;
    endcase
  endfunction

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  fscp_region_t target;
  fscp_region_t ivtRegion;
  fscp_seg_cfg_t targetSeg;
  fscp_seg_cfg_t ivtSeg;
  logic isWrite;
  logic isIvt;
  logic isAlt;
  logic isLastBoot;
  logic fromBoot;

  // page class and the settings that apply to it
  assign target = region_of(req.page, generalStart);
  assign targetSeg = seg_of(target, securityConfigWord);
  assign isWrite = (req.op != FSCP_OP_READ);
  assign isIvt = (req.page == IVT_PAGE);
  assign isAlt = bootActive && alternateVectorTable && (req.page == altPage);
  assign isLastBoot = bootActive && (req.page == altPage);
  assign fromBoot = (req.origin == FSCP_REG_BOOT);

  // vector page follows boot settings, or general ones without boot
  always_comb
  begin
    if (bootActive)
      ivtRegion = FSCP_REG_BOOT;
    else
      ivtRegion = FSCP_REG_GENERAL; // see RULE9
  end
  assign ivtSeg = seg_of(ivtRegion, securityConfigWord);

  // ----------------------------------------
  // code protection
  // ----------------------------------------
  logic crossProt;

  // protected regions refuse code from other regions except boot code, reads as well
  always_comb
  begin
    crossProt = 1'b0;
    unique case (target)
      FSCP_REG_BOOT:
        crossProt = bootActive && targetSeg.codeProt
                    && !fromBoot;                              // see RULE11
      FSCP_REG_GENERAL:
        crossProt = targetSeg.codeProt
                    && (req.origin == FSCP_REG_CONFIG);        // see RULE11
      FSCP_REG_CONFIG:
        crossProt = targetSeg.codeProt
                    && (req.origin == FSCP_REG_GENERAL);       // see RULE13
      default:
        crossProt = 1'b0;
    endcase
  end

  // ----------------------------------------
  // write protection
  // ----------------------------------------
  logic segLock;
  logic ivtLock;
  logic ivtShared;
  logic lastKeep;

  // region write protect, the alternate table page left open
  always_comb
  begin
    segLock = 1'b0;
    unique case (target)
      FSCP_REG_BOOT:
        segLock = targetSeg.writeProt && !isAlt; // see RULE6
      FSCP_REG_GENERAL:
        segLock = targetSeg.writeProt;           // see RULE13
      FSCP_REG_CONFIG:
        segLock = targetSeg.writeProt;           // see RULE2
      default:
        segLock = 1'b1;
    endcase
  end

  // vector page locked by either region's write protection
  assign ivtLock = isIvt
                   && (securityConfigWord.boot.writeProt
                       || securityConfigWord.general.writeProt); // see RULE10

  // without a boot region the vector page takes general security
  assign ivtShared = isIvt && !bootActive && ivtSeg.codeProt
                     && (req.origin != FSCP_REG_GENERAL); // see RULE9

  // boot code keeps its last page writable, but not the vector page
  assign lastKeep = isLastBoot && fromBoot && !isIvt; // see RULE7

  // ----------------------------------------
  // decision
  // ----------------------------------------
  logic allow;

  // reads meet code protection only, writes meet every lock except boot code writing its last boot page
  always_comb
  begin
    allow = !crossProt; // see RULE2
    if (isWrite)
    begin
      if (segLock || ivtLock || ivtShared)
        allow = 1'b0; // see RULE14
      if (lastKeep)
        allow = 1'b1; // see RULE7
    end
  end

  // ----------------------------------------
  // registered answer
  // ----------------------------------------
  // one answer per request, a cycle after it is taken
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resp_q <= '0;
    end
    else
    begin
      resp_q.valid <= req.valid;
      resp_q.grant <= req.valid && allow; // see RULE14
      resp_q.region <= target;
    end
  end

  // refusal flag beside the answer
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      blocked_q <= 1'b0;
    end
    else
    begin
      blocked_q <= req.valid && !allow; // see RULE14
    end
  end

endmodule

// file: tb/fscp_requester.sv
`timescale 1ns/10ps
module fscp_requester
  import fscp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // bench command in, request out
  input wire fscp_req_t cmd,
  output fscp_req_t req
);
  // nothing is issued while reset is held
  assign req = resetn ? cmd : '0;
endmodule

// file: tb/fscp_guard_assertions.sv
`timescale 1ns/10ps
module fscp_guard_assertions
  import fscp_pkg::*;
#(
  parameter logic [PAGE_BITS-1:0] CONFIG_PAGE = 13'h003F
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // watched ports
  input wire fscp_sec_cfg_t securityConfigWord,
  input wire logic [PAGE_BITS-1:0] bootPageLimit,
  input wire fscp_req_t req,
  input wire fscp_resp_t resp_q,
  input wire logic blocked_q
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // short names for request and boot window
  wire fscp_sec_cfg_t sc = securityConfigWord;
  wire logic [PAGE_BITS-1:0] lim = bootPageLimit;
  wire logic [PAGE_BITS-1:0] pg = req.page;
  wire logic wr = req.valid && req.op != FSCP_OP_READ;
  wire logic inB = sc.boot.enable && lim > 13'h0001 && lim < CONFIG_PAGE;
  // a refused answer
  sequence refused;
    resp_q.valid && blocked_q && !resp_q.grant;
  endsequence
  resp_once_a: assert property (req.valid |=> resp_q.valid)
    else $error("no answer");
  block_pair_a: assert property (
    resp_q.valid |-> blocked_q != resp_q.grant) else $error("bad flags");
  cfg_top_a: assert property (
    req.valid && pg >= CONFIG_PAGE |=> resp_q.region == FSCP_REG_CONFIG)
    else $error("not config");
  boot_span_a: assert property (
    req.valid && inB && $stable(sc) && $stable(lim) && pg < lim
    |=> resp_q.region == FSCP_REG_BOOT) else $error("not boot");
  gen_start_a: assert property (
    req.valid && inB && $stable(sc) && $stable(lim) && pg == lim
    |=> resp_q.region == FSCP_REG_GENERAL) else $error("not general");
  ivt_lock_a: assert property (
    wr && pg == IVT_PAGE && (sc.boot.writeProt || sc.general.writeProt)
    |=> refused) else $error("vector write passed");
  last_page_a: assert property (
    wr && inB && $stable(sc) && $stable(lim) && req.origin == FSCP_REG_BOOT
    && pg == lim - 1 |=> resp_q.grant) else $error("last page refused");
  boot_guard_a: assert property (
    req.valid && inB && $stable(sc) && $stable(lim) && sc.boot.codeProt
    && req.origin != FSCP_REG_BOOT && pg != IVT_PAGE && pg + 1 < lim
    |=> refused) else $error("boot open");
endmodule
bind fscp_guard fscp_guard_assertions #(.CONFIG_PAGE(CONFIG_PAGE)) u_chk (
  .ref_clk, .resetn, .securityConfigWord, .bootPageLimit, .req, .resp_q,
  .blocked_q);

// file: tb/tb.sv
`timescale 1ns/10ps
module tb
  import fscp_pkg::*;
();
  localparam fscp_op_t PG = FSCP_OP_PROGRAM;
  localparam fscp_op_t RD = FSCP_OP_READ;
  localparam fscp_region_t BT = FSCP_REG_BOOT;
  localparam fscp_region_t GN = FSCP_REG_GENERAL;
  localparam fscp_region_t CF = FSCP_REG_CONFIG;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic alternateVectorTable = 1'b0;
  logic [12:0] bootPageLimit = 13'h0004;
  fscp_sec_cfg_t securityConfigWord = '0;
  fscp_req_t cmd = '0;
  fscp_req_t req;
  fscp_resp_t resp_q;
  logic blocked_q;
  int failures = 0;
  int n_checks = 0;
  always #20 ref_clk = ~ref_clk;
  fscp_requester PRT (.ref_clk, .resetn, .cmd, .req);
  fscp_guard DUT (.ref_clk, .resetn, .securityConfigWord, .bootPageLimit,
    .alternateVectorTable, .req, .resp_q, .blocked_q);
  // compare and count
  task automatic chk(string n, logic [1:0] s, logic [1:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask
  // new settings, two edges to settle
  task automatic setup(fscp_sec_cfg_t s, logic [12:0] l, logic a);
    @(posedge ref_clk);
    securityConfigWord <= s;
    bootPageLimit <= l;
    alternateVectorTable <= a;
    repeat (2) @(posedge ref_clk);
  endtask
  // one request, answer judged one cycle later
  task automatic acc(fscp_op_t o, logic [12:0] p, fscp_region_t g,
    logic ok, fscp_region_t r);
    @(posedge ref_clk);
    cmd <= '{1'b1, o, p, g};
    @(posedge ref_clk);
    cmd <= '0;
    #1;
    chk("valid", resp_q.valid, 1'b1);
    chk("grant", resp_q.grant, ok);
    chk("blocked", blocked_q, !ok);
    chk("region", resp_q.region, r);
  endtask
  // boundaries follow the boot limit
  task automatic s_regions;
    setup(9'h124, 13'h0004, 1'b0);
    acc(RD, 13'h0003, BT, 1'b1, BT);
    acc(RD, 13'h0004, BT, 1'b1, GN);
    acc(RD, 13'h003F, BT, 1'b1, CF);
  endtask
  // write and code protection with alternate table
  task automatic s_prot;
    setup(9'h1EC, 13'h0004, 1'b1);
    acc(PG, 13'h0001, GN, 1'b0, BT);
    acc(PG, 13'h0002, BT, 1'b0, BT);
    acc(PG, 13'h0003, BT, 1'b1, BT);
    acc(FSCP_OP_PAGE_ERASE, 13'h0000, BT, 1'b0, BT);
  endtask
  // general protection alone
  task automatic s_noboot;
    setup(9'h030, 13'h0004, 1'b0);
    acc(PG, 13'h0000, GN, 1'b1, GN);
    acc(PG, 13'h0000, CF, 1'b0, GN);
    acc(RD, 13'h0002, CF, 1'b0, GN);
  endtask
  // general and config protection without a boot region
  task automatic s_gencfg;
    setup(9'h02F, 13'h0004, 1'b0);
    acc(PG, 13'h0005, GN, 1'b0, GN);
    acc(RD, 13'h0005, GN, 1'b1, GN);
    acc(RD, 13'h003F, GN, 1'b0, CF);
    acc(PG, 13'h0040, CF, 1'b0, CF);
    acc(PG, 13'h0000, GN, 1'b0, GN);
  endtask
  // smallest boot region, with and without alternate table
  task automatic s_min;
    setup(9'h124, 13'h0000, 1'b0);
    acc(RD, 13'h0001, BT, 1'b1, GN);
    setup(9'h124, 13'h0001, 1'b1);
    acc(RD, 13'h0001, BT, 1'b1, BT);
  endtask
  // counts and verdict
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // reset, then scenarios
  initial
  begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    s_regions;
    s_prot;
    s_noboot;
    s_gencfg;
    s_min;
    wrap_up;
  end
  // hang limit
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    wrap_up;
  end
endmodule
